// ### core/gcid_pkg.sv
package gcid_pkg;

	// serial word layout
	localparam int          GCID_WORD_W     = 16;
	localparam int          GCID_WR_BIT     = 15;
	localparam int          GCID_ADDR_HI    = 14;
	localparam int          GCID_ADDR_LO    = 8;
	localparam int          GCID_BYTE_HI    = 7;
	localparam logic [4:0]  GCID_FRAME_BITS = 5'h10;

	// byte addresses
	localparam logic [6:0]  GCID_A_CMD_LO   = 7'h68;
	localparam logic [6:0]  GCID_A_CMD_HI   = 7'h69;
	localparam logic [6:0]  GCID_A_FWREV    = 7'h6C;
	localparam logic [6:0]  GCID_A_DATE     = 7'h6E;
	localparam logic [6:0]  GCID_A_YEAR     = 7'h70;
	localparam logic [6:0]  GCID_A_PROD     = 7'h72;
	localparam logic [6:0]  GCID_A_SERIAL   = 7'h74;
	localparam logic [6:0]  GCID_A_SCR_A    = 7'h76;
	localparam logic [6:0]  GCID_A_SCR_B    = 7'h78;
	localparam logic [6:0]  GCID_A_SCR_C    = 7'h7A;
	localparam logic [6:0]  GCID_A_FCNT_LO  = 7'h7C;
	localparam logic [6:0]  GCID_A_FCNT_HI  = 7'h7E;

	// diagnostic flag positions
	localparam int          GCID_DIAG_BACKUP = 2;
	localparam int          GCID_DIAG_SELF   = 5;
	localparam int          GCID_DIAG_CRC    = 6;

	// reset values and the flash count increment
	localparam logic [15:0] GCID_ZERO16     = 16'h0000;
	localparam logic [7:0]  GCID_ZERO8      = 8'h00;
	localparam logic [6:0]  GCID_ZERO7      = 7'h00;
	localparam logic [4:0]  GCID_ZERO5      = 5'h00;
	localparam logic [31:0] GCID_ONE32      = 32'h0000_0001;

	// one bit per trigger, msb is trigger bit 7
	typedef struct packed {
		logic sw_reset;
		logic spare;
		logic fifo_flush;
		logic crc_test;
		logic flash_backup;
		logic self_test;
		logic factory_restore;
		logic bias_update;
	} gcid_func_t;

	localparam gcid_func_t  GCID_FUNC_NONE  = 8'h00;
	localparam gcid_func_t  GCID_FUNC_VALID = 8'hBF;

	// values held by the flash image, presented by the loader
	typedef struct packed {
		logic [15:0] fw_version;
		logic [15:0] cal_date;
		logic [15:0] cal_year;
		logic [15:0] product_id;
		logic [15:0] serial;
		logic [31:0] flash_count;
		logic [15:0] scr_a;
		logic [15:0] scr_b;
		logic [15:0] scr_c;
	} gcid_ident_t;

	typedef struct packed {
		logic [15:0] scr_a;
		logic [15:0] scr_b;
		logic [15:0] scr_c;
	} gcid_scratch_t;

	localparam gcid_scratch_t GCID_SCR_ZERO = 48'h0000_0000_0000;

	typedef enum logic [1:0] {
		GCID_SPI_IDLE  = 2'b00,
		GCID_SPI_SHIFT = 2'b01,
		GCID_SPI_END   = 2'b11
	} gcid_spi_st_t;

endpackage : gcid_pkg

// ### core/gcid_regs.sv
`timescale 1ns/1ps
module gcid_regs (
	// clock and reset
	input  wire logic                    mclk,
	input  wire logic                    rst_n,
	// serial pins from the host
	input  wire logic                    sclk,
	input  wire logic                    cs_n,
	input  wire logic                    din,
	output logic                         dout,
	// flash image and datapath
	input  gcid_pkg::gcid_ident_t        ident,
	input  wire logic                    sample_ready_in,
	output logic                         sample_ready_out,
	output logic                         data_halt,
	// function engines
	output gcid_pkg::gcid_func_t         func_start,
	input  gcid_pkg::gcid_func_t         func_done,
	input  gcid_pkg::gcid_func_t         func_fail,
	output gcid_pkg::gcid_func_t         func_busy,
	// state handed to the backup engine and status
	output gcid_pkg::gcid_scratch_t      scratch,
	output logic [15:0]                  diagnostic_flags
);
	import gcid_pkg::*;

	function automatic logic [15:0] lane_write(input logic [15:0] old_v, input logic hi,
		input logic [7:0] b);
		lane_write = hi ? {b, old_v[GCID_BYTE_HI:0]} : {old_v[15:GCID_BYTE_HI+1], b};
	endfunction : lane_write

	// registers are word wide; bit 0 of the byte address only picks the lane
	function automatic logic [6:0] word_of(input logic [6:0] a);
		word_of = {a[6:1], 1'b0};
	endfunction : word_of

	// functions still running once this cycle's completions are taken out
	function automatic gcid_func_t busy_left(input gcid_func_t busy, input gcid_func_t done);
		busy_left = busy & ~done;
	endfunction : busy_left

	// flash work owns the whole device: serial port and datapath both stop
	function automatic logic flash_work(input gcid_func_t busy);
		flash_work = busy.flash_backup | busy.factory_restore;
	endfunction : flash_work

	// pin synchronisers; only stage two and three feed logic
	// limitation: each sclk phase must last at least one mclk period,
	// otherwise an edge is lost between two samples and the frame is dropped
	logic         sclk_s1_r, sclk_s2_r, sclk_s3_r;
	logic         cs_s1_r, cs_s2_r, cs_s3_r;
	logic         din_s1_r, din_s2_r;

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			sclk_s1_r <= 1'b1;
			sclk_s2_r <= 1'b1;
			sclk_s3_r <= 1'b1;
			cs_s1_r   <= 1'b1;
			cs_s2_r   <= 1'b1;
			cs_s3_r   <= 1'b1;
			din_s1_r  <= 1'b0;
			din_s2_r  <= 1'b0;
		end
		else
		begin
			sclk_s1_r <= sclk;
			sclk_s2_r <= sclk_s1_r;
			sclk_s3_r <= sclk_s2_r;
			cs_s1_r   <= cs_n;
			cs_s2_r   <= cs_s1_r;
			cs_s3_r   <= cs_s2_r;
			din_s1_r  <= din;
			din_s2_r  <= din_s1_r;
		end
	end

	logic sclk_rise, sclk_fall, cs_fall, cs_rise;
	assign sclk_rise = sclk_s2_r & ~sclk_s3_r;
	assign sclk_fall = ~sclk_s2_r & sclk_s3_r;
	assign cs_fall   = ~cs_s2_r & cs_s3_r;
	assign cs_rise   = cs_s2_r & ~cs_s3_r;

	// control state
	gcid_func_t    busy_r, busy_nxt;
	gcid_func_t    start_r, start_nxt;
	logic [7:0]    cmd_lo_r, cmd_lo_nxt;
	logic [6:0]    rd_addr_r, rd_addr_nxt;
	gcid_scratch_t scr_r, scr_nxt;
	logic [31:0]   fcnt_r, fcnt_nxt;
	logic [15:0]   diag_r, diag_nxt;
	logic          ready_r, ready_nxt;
	logic          halt_r, halt_nxt;
	logic          quiet;

	// serial state
	gcid_spi_st_t  st_r, st_nxt;
	logic [15:0]   rx_r, rx_nxt;
	logic [15:0]   tx_r, tx_nxt;
	logic [4:0]    cnt_r, cnt_nxt;
	logic          dout_r, dout_nxt;
	logic          wv_r, wv_nxt;
	logic [15:0]   word_r, word_nxt;
	logic [15:0]   rd_data;

	// backup or restore silences the port
	assign quiet = flash_work(busy_r);

	// readback of the word addressed by the previous read frame
	always_comb
	begin
		rd_data = GCID_ZERO16;
		unique case (rd_addr_r)
			GCID_A_FWREV:   rd_data = ident.fw_version;
			GCID_A_DATE:    rd_data = ident.cal_date;
			GCID_A_YEAR:    rd_data = ident.cal_year;
			GCID_A_PROD:    rd_data = ident.product_id;
			GCID_A_SERIAL:  rd_data = ident.serial;
			GCID_A_SCR_A:   rd_data = scr_r.scr_a;
			GCID_A_SCR_B:   rd_data = scr_r.scr_b;
			GCID_A_SCR_C:   rd_data = scr_r.scr_c;
			GCID_A_FCNT_LO: rd_data = fcnt_r[15:0];
			GCID_A_FCNT_HI: rd_data = fcnt_r[31:16];
			// trigger word and unmapped words read zero
			default:        rd_data = GCID_ZERO16;
		endcase
	end

	// mode 3 framing: sample on rising edge, launch on falling edge
	always_comb
	begin
		st_nxt   = st_r;
		rx_nxt   = rx_r;
		tx_nxt   = tx_r;
		cnt_nxt  = cnt_r;
		dout_nxt = dout_r;
		wv_nxt   = 1'b0;
		word_nxt = word_r;
		unique case (st_r)
			GCID_SPI_IDLE:
			begin
				if (cs_fall)
				begin
					st_nxt   = GCID_SPI_SHIFT;
					cnt_nxt  = GCID_ZERO5;
					// no answer while flash is being written
					tx_nxt   = quiet ? GCID_ZERO16 : rd_data;
					dout_nxt = quiet ? 1'b0 : rd_data[GCID_WORD_W-1];
				end
			end
			GCID_SPI_SHIFT:
			begin
				if (sclk_rise && cnt_r < GCID_FRAME_BITS)
				begin
					rx_nxt  = {rx_r[GCID_WORD_W-2:0], din_s2_r};
					cnt_nxt = cnt_r + 5'h01;
				end
				// the first falling edge launches bit 15, already on the pin
				if (sclk_fall && cnt_r != GCID_ZERO5)
				begin
					tx_nxt   = {tx_r[GCID_WORD_W-2:0], 1'b0};
					dout_nxt = tx_r[GCID_WORD_W-2];
				end
				if (cs_rise)
					st_nxt = GCID_SPI_END;
			end
			GCID_SPI_END:
			begin
				st_nxt   = GCID_SPI_IDLE;
				dout_nxt = 1'b0;
				// frames during backup or restore are dropped
				// otherwise every full frame is served
				if (cnt_r == GCID_FRAME_BITS && !quiet)
				begin
					wv_nxt   = 1'b1;
					word_nxt = rx_r;
				end
			end
			default:
				st_nxt = GCID_SPI_IDLE;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			st_r   <= GCID_SPI_IDLE;
			rx_r   <= GCID_ZERO16;
			tx_r   <= GCID_ZERO16;
			cnt_r  <= GCID_ZERO5;
			dout_r <= 1'b0;
			wv_r   <= 1'b0;
			word_r <= GCID_ZERO16;
		end
		else
		begin
			st_r   <= st_nxt;
			rx_r   <= rx_nxt;
			tx_r   <= tx_nxt;
			cnt_r  <= cnt_nxt;
			dout_r <= dout_nxt;
			wv_r   <= wv_nxt;
			word_r <= word_nxt;
		end
	end

	// command decode, busy tracking and status
	always_comb
	begin
		logic [6:0] addr;
		logic [7:0] data;
		gcid_func_t req;
		addr        = word_r[GCID_ADDR_HI:GCID_ADDR_LO];
		data        = word_r[GCID_BYTE_HI:0];
		req         = GCID_FUNC_NONE;
		cmd_lo_nxt  = cmd_lo_r;
		rd_addr_nxt = rd_addr_r;
		scr_nxt     = scr_r;
		fcnt_nxt    = fcnt_r;
		diag_nxt    = diag_r;
		if (wv_r)
		begin
			if (word_r[GCID_WR_BIT])
			begin
				unique case (word_of(addr))
					GCID_A_CMD_LO:
					begin
						// the low byte waits for the high-byte write
						if (!addr[0])
							cmd_lo_nxt = data;
						// high-byte write fires the staged trigger bits
						// 0x80 staged then 0x00 fires software reset
						else
							req = gcid_func_t'(cmd_lo_r) & GCID_FUNC_VALID;
					end
					GCID_A_SCR_A: scr_nxt.scr_a = lane_write(scr_r.scr_a, addr[0], data);
					GCID_A_SCR_B: scr_nxt.scr_b = lane_write(scr_r.scr_b, addr[0], data);
					GCID_A_SCR_C: scr_nxt.scr_c = lane_write(scr_r.scr_c, addr[0], data);
					default: ;
				endcase
			end
			// the address is kept until the next read frame replaces it
			else
				rd_addr_nxt = word_of(addr);
		end
		// a finished restore launches a backup
		if (func_done.factory_restore)
			req.flash_backup = 1'b1;
		// one-shot: requests for a function already running are dropped
		start_nxt = req & ~busy_left(busy_r, func_done);
		busy_nxt  = busy_left(busy_r, func_done) | start_nxt;
		if (func_done.crc_test)
			diag_nxt[GCID_DIAG_CRC] = func_fail.crc_test;
		if (func_done.self_test)
			diag_nxt[GCID_DIAG_SELF] = func_fail.self_test;
		// backup outcome, each backup is one flash write
		// a failed backup still wore the flash, so it is counted too
		if (func_done.flash_backup)
		begin
			diag_nxt[GCID_DIAG_BACKUP] = func_fail.flash_backup;
			fcnt_nxt = fcnt_r + GCID_ONE32;
		end
	end

	// halt data and ready pulses for the whole backup or restore span
	always_comb
	begin
		halt_nxt  = flash_work(busy_nxt);
		// a ready pulse that meets the start of flash work is dropped, not delayed
		ready_nxt = sample_ready_in & ~halt_nxt;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			ready_r <= 1'b0;
			halt_r  <= 1'b0;
		end
		else
		begin
			ready_r <= ready_nxt;
			halt_r  <= halt_nxt;
		end
	end

	// flash image is taken at reset, so scratch and count survive power cycles
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			busy_r    <= GCID_FUNC_NONE;
			start_r   <= GCID_FUNC_NONE;
			cmd_lo_r  <= GCID_ZERO8;
			rd_addr_r <= GCID_ZERO7;
			scr_r     <= '{scr_a: ident.scr_a, scr_b: ident.scr_b, scr_c: ident.scr_c};
			fcnt_r    <= ident.flash_count;
			diag_r    <= GCID_ZERO16;
		end
		else
		begin
			busy_r    <= busy_nxt;
			start_r   <= start_nxt;
			cmd_lo_r  <= cmd_lo_nxt;
			rd_addr_r <= rd_addr_nxt;
			scr_r     <= scr_nxt;
			fcnt_r    <= fcnt_nxt;
			diag_r    <= diag_nxt;
		end
	end

	assign dout             = dout_r;
	assign sample_ready_out = ready_r;
	assign data_halt        = halt_r;
	assign func_start       = start_r;
	assign func_busy        = busy_r;
	assign scratch          = scr_r;
	assign diagnostic_flags = diag_r;

endmodule : gcid_regs

// ### verification/gcid_host.sv
`timescale 1ns/1ps
module gcid_host (
	// clock
	input  wire logic mclk,
	// serial pins
	output logic      sclk,
	output logic      cs_n,
	output logic      din,
	input  wire logic dout
);
	initial
	begin
		sclk = 1'b1;
		cs_n = 1'b1;
		din  = 1'b0;
	end
	task automatic xfer(input logic [15:0] w, output logic [15:0] r);
		@(posedge mclk);
		#2 cs_n = 1'b0;
		repeat (4) @(posedge mclk);
		for (int i = 15; i >= 0; i--)
		begin
			#2 sclk = 1'b0;
			din = w[i];
			repeat (4) @(posedge mclk);
			#2 r[i] = dout;
			sclk = 1'b1;
			repeat (4) @(posedge mclk);
		end
		#2 cs_n = 1'b1;
		// released line must not keep the last bit
		din = ~din;
		repeat (6) @(posedge mclk);
	endtask : xfer
endmodule : gcid_host

// ### verification/gcid_regs_checker.sv
`timescale 1ns/1ps
module gcid_regs_checker (
	// clock and reset
	input  wire logic           mclk,
	input  wire logic           rst_n,
	// datapath
	input  wire logic           sample_ready_in,
	input  wire logic           sample_ready_out,
	input  wire logic           data_halt,
	// engines and status
	input  gcid_pkg::gcid_func_t func_start,
	input  gcid_pkg::gcid_func_t func_done,
	input  gcid_pkg::gcid_func_t func_fail,
	input  gcid_pkg::gcid_func_t func_busy,
	input  wire logic [15:0]    diagnostic_flags
);
	import gcid_pkg::*;
	wire logic hold = func_busy.flash_backup | func_busy.factory_restore;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	spare_idle_a: assert property (!func_start.spare)
		else $error("spare trigger launched");
	busy_start_a: assert property ((func_start & ~func_busy) == GCID_FUNC_NONE)
		else $error("launch without busy");
	halt_hold_a: assert property (hold && !func_done.flash_backup |=> data_halt)
		else $error("no halt during flash work");
	ready_gate_a: assert property (hold && !func_done.flash_backup |=> !sample_ready_out)
		else $error("ready pulse during flash work");
	ready_pass_a: assert property (sample_ready_in && !hold ##1 !data_halt |-> sample_ready_out)
		else $error("ready pulse lost");
	restore_chain_a: assert property (func_done.factory_restore && func_busy.factory_restore
		|=> func_start.flash_backup && !func_busy.factory_restore)
		else $error("no backup after restore");
	backup_flag_a: assert property (func_done.flash_backup && func_busy.flash_backup
		|=> diagnostic_flags[2] == $past(func_fail.flash_backup))
		else $error("backup flag wrong");
	crc_flag_a: assert property (func_done.crc_test && func_busy.crc_test
		|=> diagnostic_flags[6] == $past(func_fail.crc_test))
		else $error("crc flag wrong");
	self_flag_a: assert property (func_done.self_test && func_busy.self_test
		|=> diagnostic_flags[5] == $past(func_fail.self_test))
		else $error("self test flag wrong");
	one_shot_a: assert property (|func_start |=> (func_start & $past(func_start)) == 8'h00)
		else $error("launch longer than one cycle");
	flag_spare_a: assert property ((diagnostic_flags & 16'hFF9B) == 16'h0000)
		else $error("undefined flag set");
	cover property (func_done.factory_restore);
	cover property (hold && sample_ready_in);
	cover property (func_start.sw_reset);
endmodule : gcid_regs_checker
bind gcid_regs gcid_regs_checker chk_u (.mclk(mclk), .rst_n(rst_n),
	.sample_ready_in(sample_ready_in), .sample_ready_out(sample_ready_out),
	.data_halt(data_halt), .func_start(func_start), .func_done(func_done),
	.func_fail(func_fail), .func_busy(func_busy), .diagnostic_flags(diagnostic_flags));

// ### verification/gcid_regs_tb.sv
`timescale 1ns/1ps
module gcid_regs_tb;
	import gcid_pkg::*;
	logic          mclk = 1'b0;
	logic          rst_n = 1'b0;
	logic          sclk, cs_n, din, dout;
	logic          sample_ready_in, sample_ready_out, data_halt;
	gcid_ident_t   ident;
	gcid_func_t    func_start, func_done, func_fail, func_busy, seen, pend;
	gcid_scratch_t scratch;
	logic [15:0]   diagnostic_flags, rd_v, cnt, tick;
	logic [7:0]    exp_c;
	int            fail_count = 0;
	int            num_checks = 0;
	logic [6:0]    ra [10] = '{GCID_A_FWREV, GCID_A_DATE, GCID_A_YEAR, GCID_A_PROD, GCID_A_PROD,
		GCID_A_SERIAL, GCID_A_FCNT_LO, GCID_A_FCNT_HI, GCID_A_CMD_LO, 7'h6A};
	logic [15:0]   rx [10] = '{16'h0213, 16'h0815, 16'h2031, 16'h5A5A, 16'h5A5A,
		16'h0C3E, 16'hFFFE, 16'h0001, 16'h0000, 16'h0000};
	always #12.5 mclk = ~mclk;
	gcid_host host_u (.mclk(mclk), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));
	gcid_regs dut_u (.mclk(mclk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .din(din),
		.dout(dout), .ident(ident), .sample_ready_in(sample_ready_in),
		.sample_ready_out(sample_ready_out), .data_halt(data_halt), .func_start(func_start),
		.func_done(func_done), .func_fail(func_fail), .func_busy(func_busy),
		.scratch(scratch), .diagnostic_flags(diagnostic_flags));
	// engines answer 400 cycles after launch, long enough to cover a frame
	always @(posedge mclk)
	begin
		func_done <= GCID_FUNC_NONE;
		tick <= tick + 16'h0001;
		sample_ready_in <= (tick[3:0] == 4'h0);
		seen <= seen | func_start;
		if (|func_start)
		begin
			pend <= func_start;
			cnt <= 16'h0190;
		end
		else if (cnt != 16'h0000)
		begin
			cnt <= cnt - 16'h0001;
			if (cnt == 16'h0001)
				func_done <= pend;
		end
	end
	task automatic check(input string what, input logic [15:0] got, input logic [15:0] want);
		num_checks++;
		if (got !== want)
		begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, want, got);
		end
	endtask : check
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [15:0] r;
		host_u.xfer({1'b1, a, d}, r);
	endtask : wr
	task automatic rd(input logic [6:0] a, output logic [15:0] v);
		logic [15:0] r;
		host_u.xfer({1'b0, a, 8'h00}, r);
		host_u.xfer(16'h0000, v);
	endtask : rd
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : give_verdict
	initial
	begin
		repeat (60000) @(posedge mclk);
		fail_count++;
		give_verdict();
	end
	initial
	begin
		// product identifier value is arbitrary
		ident = {16'h0213, 16'h0815, 16'h2031, 16'h5A5A, 16'h0C3E, 32'h0001_FFFE,
			16'h1111, 16'h2222, 16'h3333};
		func_done = GCID_FUNC_NONE;
		// crc and backup report failure, self test passes
		func_fail = 8'h18;
		sample_ready_in = 1'b0;
		tick = 16'h0000;
		cnt = 16'h0000;
		seen = GCID_FUNC_NONE;
		pend = GCID_FUNC_NONE;
		exp_c = 8'h33;
		repeat (3) @(posedge mclk);
		#2 rst_n = 1'b1;
		repeat (4) @(posedge mclk);
		wr(GCID_A_FWREV, 8'hAA);
		for (int i = 0; i < 10; i++)
		begin
			rd(ra[i], rd_v);
			check("ident word", rd_v, rx[i]);
		end
		wr(GCID_A_SCR_A, 8'h34);
		wr(GCID_A_SCR_A | 7'h01, 8'h12);
		rd(GCID_A_SCR_A, rd_v);
		check("scratch a", rd_v, 16'h1234);
		rd(GCID_A_SCR_B, rd_v);
		check("scratch b", rd_v, 16'h2222);
		check("scratch port", scratch.scr_a, 16'h1234);
		for (int b = 7; b >= 0; b--)
		begin
			#2 seen = GCID_FUNC_NONE;
			wr(GCID_A_CMD_LO, 8'h01 << b);
			wr(GCID_A_CMD_HI, 8'h00);
			repeat (30) @(posedge mclk);
			check("launch", {8'h00, seen}, {8'h00, GCID_FUNC_VALID & (8'h01 << b)});
			check("halt", {15'h0000, data_halt}, {15'h0000, 1'(b == 3 || b == 1)});
			wr(GCID_A_SCR_C, 8'(b));
			if (b != 3 && b != 1)
				exp_c = 8'(b);
			check("write while busy", {8'h00, scratch.scr_c[7:0]}, {8'h00, exp_c});
			for (int k = 0; k < 2000 && func_busy !== GCID_FUNC_NONE; k++)
				@(posedge mclk);
			check("busy", {8'h00, func_busy}, 16'h0000);
		end
		check("diagnostic", diagnostic_flags, 16'h0044);
		rd(GCID_A_FCNT_LO, rd_v);
		check("count low", rd_v, 16'h0000);
		rd(GCID_A_FCNT_HI, rd_v);
		check("count high", rd_v, 16'h0002);
		give_verdict();
	end
endmodule : gcid_regs_tb
